// file: rtl/wwc_watchdog_config.sv
// Window watchdog configuration, freeze, fault counting and restart request logic
//
// Contract
// - Close window is 10, 20, 50 or 100 ms from timing bits 7-6.
// - Open window is 20, 100, 200 or 600 ms from timing bits 5-4.
// - Long open window is 200, 600, 2000 or 5000 ms from bits 3-2.
// - Freeze bit set blocks writes to all watchdog controls, itself included.
// - Once freeze is written 1, writes of 0 are ignored until reset.
// - Freeze never blocks status clears of restart flag or pulse counter.
// - Reload bit set requests default reload during the restart sequence.
// - Pull-down bit drives the trigger pin pull-down enable.
// - Polarity bit 0 gives active-high fault output, 1 active-low.
// - Drive-type bit 0 push-pull, 1 open-drain; resets to 1.
// - Window, threshold and config fields take defaults from programmed memory; the code loads config bits 4-0 only, leaving freeze and bits 6-5 alone.
// - Restart flag sets on each watchdog restart and holds until cleared.
// - Writing a clear bit gives one clear pulse; it reads back 0.
// - Fault pulse count reads at status bits 1-0.
`timescale 1ns/1ps
module wwc_watchdog_config #(
  parameter int unsigned CYCLES_PER_MS = wwc_pkg::MS_CYCLES
) (
  input wire logic mclk, // 125 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire wwc_pkg::wwc_req_s reg_req, // Register access from the serial port
  output logic [7:0] reg_rdata, // Read data, valid the cycle after rd
  input wire logic otp_load, // Pulse: load defaults from programmed memory
  input wire logic [7:0] otp_timing, // Programmed default of the timing register
  input wire logic [4:0] otp_config, // Programmed defaults of config bits 4-0
  input wire logic fault_req, // Window checker asks for a fault, active high
  output logic fault_out, // Fault output pin level
  output logic fault_out_oe, // Fault output pin drive enable
  output logic trigger_pin_pulldown, // Pull-down enable of the trigger pin
  output logic [31:0] close_window_cycles, // Close window length in clocks
  output logic [31:0] open_window_cycles, // Open window length in clocks
  output logic [31:0] long_window_cycles, // Long open window length in clocks
  output logic restart_req, // Pulse: start a system restart
  output logic reload_defaults_req // Pulse: reload defaults within that restart
);
  logic [7:0] timing;
  logic [7:0] config_reg;
  logic [2:0] status_rsv;
  logic restart_occurred_flag;
  logic [1:0] fault_pulse_count;
  logic fault_prev;

  // Decode
  wire freeze = config_reg[wwc_pkg::FREEZE_BIT];
  wire timing_wr = reg_req.wr && reg_req.addr == wwc_pkg::TIMING_ADDR && !freeze;
  wire config_wr = reg_req.wr && reg_req.addr == wwc_pkg::CONFIG_ADDR && !freeze;
  wire status_wr = reg_req.wr && reg_req.addr == wwc_pkg::STATUS_ADDR;
  wire clr_flag = status_wr && reg_req.wdata[wwc_pkg::ST_CLR_FLAG_BIT];
  wire clr_count = status_wr && reg_req.wdata[wwc_pkg::ST_CLR_CNT_BIT];

  // Fault counting and threshold compare
  wire [1:0] thr_sel = timing[wwc_pkg::THR_LSB +: 2];
  wire [2:0] thr = wwc_pkg::THR_PULSES[thr_sel];
  wire rise = fault_req && !fault_prev;
  wire [2:0] count_inc = {1'b0, fault_pulse_count} + 3'h1;
  wire hit = rise && thr != 3'h0 && count_inc >= thr;
  wire blocked = config_reg[wwc_pkg::BLOCK_BIT] && restart_occurred_flag;
  wire fire = hit && !blocked;
  wire [1:0] count_sat = (fault_pulse_count == 2'h3) ? 2'h3 : count_inc[1:0];
  // A pulse that lands on a clear still counts, so no fault is lost
  wire [1:0] count_base = clr_count ? wwc_pkg::COUNT_RST : fault_pulse_count;
  wire [1:0] next_count = fire ? wwc_pkg::COUNT_RST
                        : rise ? ((clr_count) ? 2'h1 : count_sat)
                        : count_base;
  wire next_flag = fire || (restart_occurred_flag && !clr_flag);

  wire [1:0] close_window_sel = timing[wwc_pkg::CLOSE_LSB +: 2];
  wire [1:0] open_window_sel = timing[wwc_pkg::OPEN_LSB +: 2];
  wire [1:0] long_first_window_sel = timing[wwc_pkg::LONG_LSB +: 2];

  wire level = fault_req ^ config_reg[wwc_pkg::POL_BIT];
  wire [7:0] next_rdata = !reg_req.rd ? 8'h00
    : reg_req.addr == wwc_pkg::TIMING_ADDR ? timing
    : reg_req.addr == wwc_pkg::CONFIG_ADDR ? config_reg
    : reg_req.addr == wwc_pkg::STATUS_ADDR ? {status_rsv, 1'b0, restart_occurred_flag, 1'b0, fault_pulse_count}
    : 8'h00;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      timing <= wwc_pkg::TIMING_RST;
    end else if (otp_load) begin
      timing <= otp_timing;
    end else if (timing_wr) begin
      timing <= reg_req.wdata;
    end
  end

  // Programmed reload leaves the freeze bit alone: only reset clears it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      config_reg <= wwc_pkg::CONFIG_RST;
    end else if (otp_load) begin
      config_reg[4:0] <= otp_config;
    end else if (config_wr) begin
      config_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      status_rsv <= wwc_pkg::STATUS_RSV_RST;
    end else if (status_wr) begin
      status_rsv <= reg_req.wdata[wwc_pkg::ST_RSV_LSB +: 3];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      restart_occurred_flag <= 1'b0;
      fault_pulse_count <= wwc_pkg::COUNT_RST;
      fault_prev <= 1'b0;
      restart_req <= 1'b0;
      reload_defaults_req <= 1'b0;
    end else begin
      restart_occurred_flag <= next_flag;
      fault_pulse_count <= next_count;
      fault_prev <= fault_req;
      restart_req <= fire;
      reload_defaults_req <= fire && config_reg[wwc_pkg::RELOAD_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fault_out <= 1'b0;
      fault_out_oe <= 1'b1;
      trigger_pin_pulldown <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      fault_out <= level;
      fault_out_oe <= !config_reg[wwc_pkg::OD_BIT] || !level;
      trigger_pin_pulldown <= config_reg[wwc_pkg::PD_BIT];
      reg_rdata <= next_rdata;
    end
  end

  // Durations are products of small tables; registering them keeps the multipliers off the outputs
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      close_window_cycles <= 32'(wwc_pkg::CLOSE_MS[0] * CYCLES_PER_MS);
      open_window_cycles <= 32'(wwc_pkg::OPEN_MS[0] * CYCLES_PER_MS);
      long_window_cycles <= 32'(wwc_pkg::LONG_MS[0] * CYCLES_PER_MS);
    end else begin
      close_window_cycles <= 32'(wwc_pkg::CLOSE_MS[close_window_sel] * CYCLES_PER_MS);
      open_window_cycles <= 32'(wwc_pkg::OPEN_MS[open_window_sel] * CYCLES_PER_MS);
      long_window_cycles <= 32'(wwc_pkg::LONG_MS[long_first_window_sel] * CYCLES_PER_MS);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  freeze_holds_a: assert property (freeze |=> freeze) else $error("freeze bit cleared");
  frozen_timing_a: assert property (freeze && !otp_load |=> $stable(timing))
    else $error("frozen timing changed");
  frozen_config_a: assert property (freeze && !otp_load |=> $stable(config_reg))
    else $error("frozen config changed");
  close_time_a: assert property (##1 close_window_cycles ==
    32'(wwc_pkg::CLOSE_MS[$past(timing[7:6])] * CYCLES_PER_MS)) else $error("close window wrong");
  open_time_a: assert property (##1 open_window_cycles ==
    32'(wwc_pkg::OPEN_MS[$past(timing[5:4])] * CYCLES_PER_MS)) else $error("open window wrong");
  long_time_a: assert property (##1 long_window_cycles ==
    32'(wwc_pkg::LONG_MS[$past(timing[3:2])] * CYCLES_PER_MS)) else $error("long window wrong");
  single_thresh_a: assert property (rise && thr_sel == 2'h1 && !blocked |=> restart_req)
    else $error("restart missed at one pulse");
  restart_block_a: assert property (blocked |=> !restart_req) else $error("blocked restart fired");
  flag_set_a: assert property (restart_req |-> restart_occurred_flag) else $error("flag not set");
  flag_clear_a: assert property (clr_flag && !fire |=> !restart_occurred_flag)
    else $error("flag clear lost");
  reload_pair_a: assert property (reload_defaults_req |-> restart_req && $past(config_reg[3]))
    else $error("reload without restart");
  fault_level_a: assert property (##1 fault_out == ($past(fault_req) ^ $past(config_reg[1])))
    else $error("fault polarity wrong");
  drive_type_a: assert property (##1 fault_out_oe == (!$past(config_reg[0]) || !fault_out))
    else $error("drive type wrong");
  count_step_a: assert property (rise && !fire && !clr_count && fault_pulse_count != 2'h3
    |=> fault_pulse_count == $past(fault_pulse_count) + 2'h1) else $error("count step wrong");

  // Freeze and status access
  freeze_set_a: assert property (config_wr && !otp_load && reg_req.wdata[wwc_pkg::FREEZE_BIT] |=> freeze)
    else $error("freeze not taken");
  frozen_clear_a: assert property (freeze && clr_flag && !fire |=> !restart_occurred_flag)
    else $error("frozen flag clear lost");
  count_clear_a: assert property (clr_count && !rise |=> fault_pulse_count == wwc_pkg::COUNT_RST)
    else $error("count clear lost");
  flag_hold_a: assert property (restart_occurred_flag && !clr_flag |=> restart_occurred_flag)
    else $error("restart flag dropped");
  status_read_a: assert property (reg_req.rd && reg_req.addr == wwc_pkg::STATUS_ADDR |=>
    reg_rdata[1:0] == $past(fault_pulse_count)) else $error("count read wrong");
  clear_bits_a: assert property (reg_req.rd && reg_req.addr == wwc_pkg::STATUS_ADDR |=>
    !reg_rdata[wwc_pkg::ST_CLR_FLAG_BIT] && !reg_rdata[wwc_pkg::ST_CLR_CNT_BIT])
    else $error("clear bit reads one");

  // Restart and counting
  thresh_off_a: assert property (thr_sel == 2'h0 |=> !restart_req)
    else $error("restart while disabled");
  restart_pulse_a: assert property (restart_req |=> !restart_req)
    else $error("restart longer than one cycle");
  count_reset_a: assert property (restart_req |-> fault_pulse_count == wwc_pkg::COUNT_RST)
    else $error("count not cleared by restart");
  reload_off_a: assert property (!config_reg[wwc_pkg::RELOAD_BIT] |=> !reload_defaults_req)
    else $error("reload while disabled");
  thresh_two_a: assert property (rise && thr_sel == 2'h2 && fault_pulse_count == 2'h1 && !blocked
    |=> restart_req)
    else $error("restart missed at two pulses");

  // Defaults, pins and timing writes
  otp_timing_a: assert property (otp_load |=> timing == $past(otp_timing))
    else $error("timing default not loaded");
  otp_config_a: assert property (otp_load |=>
    config_reg[4:0] == $past(otp_config) && freeze == $past(freeze))
    else $error("config default not loaded");
  pin_pulldown_a: assert property (##1 trigger_pin_pulldown == $past(config_reg[wwc_pkg::PD_BIT]))
    else $error("pull-down select wrong");
  timing_write_a: assert property (timing_wr && !otp_load |=> timing == $past(reg_req.wdata))
    else $error("timing write lost");
endmodule

// file: include/wwc_pkg.sv
// Constants, register map and carrier types for the window watchdog configuration block
package wwc_pkg;
  // Register offsets
  localparam logic [7:0] TIMING_ADDR = 8'h1c;
  localparam logic [7:0] CONFIG_ADDR = 8'h1d;
  localparam logic [7:0] STATUS_ADDR = 8'h1e;
  // Reset values
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h01;
  localparam logic [2:0] STATUS_RSV_RST = 3'h0;
  localparam logic [1:0] COUNT_RST = 2'h0;
  // Timing register field positions (each field two bits wide)
  localparam int CLOSE_LSB = 6;
  localparam int OPEN_LSB = 4;
  localparam int LONG_LSB = 2;
  localparam int THR_LSB = 0;
  // Output configuration register bit positions
  localparam int FREEZE_BIT = 7;
  localparam int RSV_HI_BIT = 6;
  localparam int RSV_LO_BIT = 5;
  localparam int BLOCK_BIT = 4;
  localparam int RELOAD_BIT = 3;
  localparam int PD_BIT = 2;
  localparam int POL_BIT = 1;
  localparam int OD_BIT = 0;
  // Status register bit positions
  localparam int ST_RSV_LSB = 5;
  localparam int ST_CLR_FLAG_BIT = 4;
  localparam int ST_FLAG_BIT = 3;
  localparam int ST_CLR_CNT_BIT = 2;
  // Window durations in ms, indexed by the 2-bit select code
  localparam int unsigned CLOSE_MS [4] = '{10, 20, 50, 100};
  localparam int unsigned OPEN_MS [4] = '{20, 100, 200, 600};
  localparam int unsigned LONG_MS [4] = '{200, 600, 2000, 5000};
  // Fault pulses needed for a restart; zero disables restart
  localparam logic [2:0] THR_PULSES [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  // Clock rate and derived cycles per millisecond
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned MS_CYCLES = CLK_KHZ;
  // Register port request from the serial interface
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wwc_req_s;
endpackage

// file: sim/wwc_host_model.sv
// Host side model that produces isolated fault pulses on command
`timescale 1ns/1ps
module wwc_host_model (
  input wire logic mclk, // Bench clock
  input wire logic fire, // Request one fault pulse
  output logic fault_req // Fault request toward the block
);
  initial fault_req = 1'b0;
  // Self-clearing, so back-to-back requests still leave a low cycle between pulses
  always @(negedge mclk) begin
    fault_req <= fire && !fault_req;
  end
endmodule

// file: sim/window_watchdog_config_test.sv
// Register-level tests of the window watchdog configuration block
`timescale 1ns/1ps
module window_watchdog_config_test;
  localparam int CPM = 4;
  logic mclk, rstn, otp_load, fire, fault_req;
  logic [7:0] otp_timing;
  logic [4:0] otp_config;
  wwc_pkg::wwc_req_s req;
  logic [7:0] reg_rdata;
  logic fault_out, fault_out_oe, trigger_pin_pulldown, restart_req, reload_defaults_req;
  logic [31:0] close_window_cycles, open_window_cycles, long_window_cycles;
  int failures, checks, restarts, reloads;
  wwc_watchdog_config #(.CYCLES_PER_MS(CPM)) DUT (.mclk(mclk), .rstn(rstn), .reg_req(req),
    .reg_rdata(reg_rdata), .otp_load(otp_load), .otp_timing(otp_timing), .otp_config(otp_config),
    .fault_req(fault_req), .fault_out(fault_out), .fault_out_oe(fault_out_oe),
    .trigger_pin_pulldown(trigger_pin_pulldown), .close_window_cycles(close_window_cycles),
    .open_window_cycles(open_window_cycles), .long_window_cycles(long_window_cycles),
    .restart_req(restart_req), .reload_defaults_req(reload_defaults_req));
  wwc_host_model host (.mclk(mclk), .fire(fire), .fault_req(fault_req));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rstn && restart_req === 1'b1) restarts++;
    if (rstn && reload_defaults_req === 1'b1) reloads++;
  end
  task check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) req = '{1'b1, 1'b0, a, d};
    @(negedge mclk) req = '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk) req = '0;
    check(reg_rdata, e);
  endtask
  task pulse;
    @(negedge mclk) fire <= 1'b1;
    @(negedge mclk) fire <= 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task complete_run;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    // Whole sequence needs well under a thousand cycles
    #200000;
    failures++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    otp_load = 1'b0;
    fire = 1'b0;
    otp_timing = 8'h00;
    otp_config = 5'h00;
    req = '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    rd(8'h1c, 8'h00);
    rd(8'h1d, 8'h01);
    rd(8'h1e, 8'h00);
    rd(8'h20, 8'h00);
    check(fault_out_oe, 1);
    check(trigger_pin_pulldown, 0);
    check(long_window_cycles, 200 * CPM);
    for (int i = 0; i < 4; i++) begin
      wr(8'h1c, {i[1:0], i[1:0], i[1:0], 2'h0});
      @(negedge mclk);
      check(close_window_cycles, wwc_pkg::CLOSE_MS[i] * CPM);
      check(open_window_cycles, wwc_pkg::OPEN_MS[i] * CPM);
      check(long_window_cycles, wwc_pkg::LONG_MS[i] * CPM);
    end
    wr(8'h1d, 8'h06);
    @(negedge mclk);
    check({trigger_pin_pulldown, fault_out, fault_out_oe}, 3'h7);
    wr(8'h1d, 8'h03);
    @(negedge mclk);
    check({trigger_pin_pulldown, fault_out, fault_out_oe}, 3'h2);
    wr(8'h1d, 8'h08);
    wr(8'h1c, 8'h01);
    pulse();
    check(restarts, 1);
    check(reloads, 1);
    rd(8'h1e, 8'h08);
    wr(8'h1d, 8'h00);
    wr(8'h1e, 8'h10);
    rd(8'h1e, 8'h00);
    wr(8'h1c, 8'h02);
    pulse();
    rd(8'h1e, 8'h01);
    pulse();
    check(restarts, 2);
    check(reloads, 1);
    wr(8'h1d, 8'h10);
    wr(8'h1c, 8'h01);
    pulse();
    check(restarts, 2);
    wr(8'h1e, 8'h10);
    pulse();
    check(restarts, 3);
    wr(8'h1d, 8'h00);
    wr(8'h1c, 8'h03);
    wr(8'h1e, 8'h14);
    repeat (3) pulse();
    rd(8'h1e, 8'h03);
    pulse();
    check(restarts, 4);
    wr(8'h1c, 8'h00);
    // Only the counter is cleared, so the flag set by the last restart stays for the frozen clear below
    wr(8'h1e, 8'h04);
    pulse();
    check(restarts, 4);
    rd(8'h1e, 8'h09);
    otp_timing = 8'he4;
    otp_config = 5'h15;
    @(negedge mclk) otp_load = 1'b1;
    @(negedge mclk) otp_load = 1'b0;
    rd(8'h1c, 8'he4);
    rd(8'h1d, 8'h15);
    wr(8'h1d, 8'h80);
    rd(8'h1d, 8'h80);
    wr(8'h1d, 8'h00);
    rd(8'h1d, 8'h80);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'he4);
    wr(8'h1e, 8'h14);
    rd(8'h1e, 8'h00);
    // Mid-run reset is the only way out of the freeze
    @(negedge mclk) rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    rd(8'h1d, 8'h01);
    rd(8'h1e, 8'h00);
    wr(8'h1d, 8'h60);
    rd(8'h1d, 8'h60);
    complete_run();
  end
endmodule
